//--- rtl/tmcc_core.sv
// Purpose: shared core of a timer module: counter, two comparators, pins, byte port
// Assumes: high-speed and sub clocks arrive as enables on this clock domain
// Notes: external pins pass two flip-flops before edge detection
// What this block does
// - free-running up-counter compared against comparators
// - match raises request, may clear, drives output
// - three-bit field selects counter clock
// - sources: system, high-speed divided, sub, pin
// - external pin counts rising or falling edge
// - separate requests for comparator A and P
// - capture edge rising, falling or both
// - clock pin triggers single pulse mode
// - periodic type may capture from clock pin
// - inverted output is inverse of output
// - compare match sets, clears or toggles output
// - pwm uses the same output pin pair
// - mode set per timer type capability
// - edge aligned pwm, duty or period
// - registers split into low and high bytes
// - buffer moves only on low byte write or high byte read
// - low byte write touches buffer only
// - high write loads high and copies buffer
// - high read snapshots low into buffer
// - low read returns the holding buffer
// - ten-bit upward counter
// - on rising edge clears counter; off freezes
// - pause holds counter, resume continues
module tmcc_core
	import tmcc_pkg::*;
#(
	parameter bit HAS_CAPTURE = 1'b1,
	parameter bit IS_PERIODIC = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic module_on_control_i,
	input wire logic counter_pause_control_i,
	input wire logic [2:0] counter_clock_select_i,
	input wire tmcc_mode_t mode_i,
	input wire logic [1:0] output_action_i,
	input wire logic output_initial_i,
	input wire logic clear_on_a_i,
	input wire logic [1:0] capture_edge_select_i,
	input wire logic capture_from_clock_pin_i,
	input wire logic high_speed_tick_i,
	input wire logic sub_clock_tick_i,
	input wire logic external_clock_pin_i,
	input wire logic capture_pin_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_a_o,
	output logic irq_p_o,
	output logic capture_event_o,
	output logic timer_output_pin_o,
	output logic timer_output_inverted_pin_o
);
	logic [PRESC_W-1:0] sys_presc;
	logic [PRESC_W-1:0] hs_presc;
	logic [2:0] ext_sync;
	logic [2:0] cap_sync;
	logic on_q;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] cmp_a;
	logic [CNT_W-1:0] cmp_p;
	logic [7:0] hold_buf;
	logic out_q;
	logic single_armed;
	logic tick;
	logic ext_rise;
	logic ext_fall;
	logic cap_rise;
	logic cap_fall;
	logic match_a;
	logic match_p;
	logic cap_hit;
	logic trig_hit;
	logic mode_ok;

	function automatic logic edge_sel(input logic [1:0] sel, input logic r, input logic f);
		edge_sel = (sel == CAP_RISE) ? r : (sel == CAP_FALL) ? f : (sel == CAP_BOTH) ? (r | f) : 1'b0;
	endfunction

	function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
		hi_byte = {6'h00, v[CNT_W-1:8]};
	endfunction

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_sync <= 3'h0;
			cap_sync <= 3'h0;
		end else begin
			ext_sync <= {ext_sync[1:0], external_clock_pin_i};
			cap_sync <= {cap_sync[1:0], capture_pin_i};
		end
	end

	assign ext_rise = ext_sync[1] & ~ext_sync[2];
	assign ext_fall = ~ext_sync[1] & ext_sync[2];
	assign cap_rise = cap_sync[1] & ~cap_sync[2];
	assign cap_fall = ~cap_sync[1] & cap_sync[2];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_presc <= 6'h00;
			hs_presc <= 6'h00;
		end else begin
			sys_presc <= sys_presc + 6'h01;
			if (high_speed_tick_i) begin
				hs_presc <= hs_presc + 6'h01;
			end
		end
	end

	always_comb begin
		unique case (counter_clock_select_i)
			CKS_SYS_DIV4: tick = (sys_presc[1:0] & DIV4_MASK[1:0]) == 2'h3;
			CKS_SYS: tick = 1'b1;
			CKS_HS_DIV16: tick = high_speed_tick_i && (hs_presc[3:0] & DIV16_MASK[3:0]) == 4'hF;
			CKS_HS_DIV64: tick = high_speed_tick_i && (hs_presc & DIV64_MASK) == 6'h3F;
			CKS_SUB_A, CKS_SUB_B: tick = sub_clock_tick_i;
			CKS_EXT_RISE: tick = ext_rise;
			CKS_EXT_FALL: tick = ext_fall;
		endcase
	end

	// compact type accepts only compare and pwm modes
	assign mode_ok = HAS_CAPTURE || mode_i == TMCC_MODE_CMP || mode_i == TMCC_MODE_PWM;
	assign match_a = tick && count == cmp_a;
	assign match_p = tick && count == cmp_p;
	assign cap_hit = HAS_CAPTURE && mode_ok && mode_i == TMCC_MODE_CAPTURE &&
		((IS_PERIODIC && capture_from_clock_pin_i) ? edge_sel(capture_edge_select_i, ext_rise, ext_fall)
		: edge_sel(capture_edge_select_i, cap_rise, cap_fall));
	assign trig_hit = HAS_CAPTURE && mode_i == TMCC_MODE_SINGLE && ext_rise;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			on_q <= 1'b0;
		end else begin
			on_q <= module_on_control_i;
		end
	end

	// clear on switch-on, freeze when off
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= CNT_RST;
		end else if (module_on_control_i && !on_q) begin
			count <= CNT_RST;
		end else if (module_on_control_i && !counter_pause_control_i && tick) begin
			if ((clear_on_a_i && match_a) || (!clear_on_a_i && match_p)) begin
				count <= CNT_RST;
			end else begin
				count <= count + 10'h001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_a_o <= 1'b0;
			irq_p_o <= 1'b0;
			capture_event_o <= 1'b0;
		end else begin
			irq_a_o <= module_on_control_i && !counter_pause_control_i && match_a;
			irq_p_o <= module_on_control_i && !counter_pause_control_i && (match_p || cap_hit);
			capture_event_o <= cap_hit;
		end
	end

	// edge aligned, period by p, duty by a
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_q <= 1'b0;
			single_armed <= 1'b0;
		end else if (module_on_control_i && !on_q) begin
			out_q <= output_initial_i;
			single_armed <= 1'b0;
		end else if (module_on_control_i && !counter_pause_control_i) begin
			unique case (mode_i)
				TMCC_MODE_CMP: begin
					if (match_a) begin
						unique case (output_action_i)
							ACT_NONE: out_q <= out_q;
							ACT_LOW: out_q <= 1'b0;
							ACT_HIGH: out_q <= 1'b1;
							ACT_TOGGLE: out_q <= ~out_q;
						endcase
					end
				end
				TMCC_MODE_PWM: begin
					if (match_p) begin
						out_q <= ~output_initial_i;
					end else if (match_a) begin
						out_q <= output_initial_i;
					end
				end
				TMCC_MODE_SINGLE: begin
					if (trig_hit && !single_armed) begin
						single_armed <= 1'b1;
						out_q <= ~output_initial_i;
					end else if (single_armed && match_a) begin
						single_armed <= 1'b0;
						out_q <= output_initial_i;
					end
				end
				TMCC_MODE_CAPTURE: out_q <= out_q;
			endcase
		end
	end

	assign timer_output_pin_o = out_q;
	assign timer_output_inverted_pin_o = ~out_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_buf <= BUF_RST;
			cmp_a <= CNT_RST;
			cmp_p <= CNT_RST;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				ADDR_CMPA_LO, ADDR_CMPP_LO: hold_buf <= reg_wdata_i;
				ADDR_CMPA_HI: cmp_a <= {reg_wdata_i[1:0], hold_buf};
				ADDR_CMPP_HI: cmp_p <= {reg_wdata_i[1:0], hold_buf};
				default: hold_buf <= hold_buf;
			endcase
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_CNT_HI: hold_buf <= count[7:0];
				ADDR_CMPA_HI: hold_buf <= cmp_a[7:0];
				ADDR_CMPP_HI: hold_buf <= cmp_p[7:0];
				default: hold_buf <= hold_buf;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_CNT_LO, ADDR_CMPA_LO, ADDR_CMPP_LO: reg_rdata_o <= hold_buf;
				ADDR_CNT_HI: reg_rdata_o <= hi_byte(count);
				ADDR_CMPA_HI: reg_rdata_o <= hi_byte(cmp_a);
				ADDR_CMPP_HI: reg_rdata_o <= hi_byte(cmp_p);
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	chk_high_write_commit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_wr_i && reg_addr_i == ADDR_CMPA_HI |=> cmp_a == {$past(reg_wdata_i[1:0]), $past(hold_buf)})
		else $error("comparator a not committed");
	chk_low_write_buf: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_wr_i && reg_addr_i == ADDR_CMPA_LO |=> $stable(cmp_a) && hold_buf == $past(reg_wdata_i))
		else $error("low write changed comparator");
	chk_high_read_snap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_CNT_HI |=> hold_buf == $past(count[7:0]))
		else $error("counter low not snapshotted");
	chk_low_read_buf: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_rd_i && reg_addr_i == ADDR_CNT_LO |=> reg_rdata_o == $past(hold_buf))
		else $error("low read not from buffer");
	chk_out_inverse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		timer_output_inverted_pin_o == ~timer_output_pin_o)
		else $error("output pair not complementary");
	chk_on_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		module_on_control_i && !on_q |=> count == CNT_RST)
		else $error("counter not cleared on switch-on");
	chk_pause_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		on_q && module_on_control_i && counter_pause_control_i |=> $stable(count))
		else $error("counter moved while paused");
	chk_match_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		module_on_control_i && !counter_pause_control_i && match_a |=> irq_a_o)
		else $error("missing comparator a request");
	chk_toggle_action: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		on_q && module_on_control_i && !counter_pause_control_i && mode_i == TMCC_MODE_CMP
		&& output_action_i == ACT_TOGGLE && match_a |=> timer_output_pin_o != $past(timer_output_pin_o))
		else $error("toggle action missed");
	chk_ext_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		counter_clock_select_i == CKS_EXT_RISE && !ext_rise |-> !tick)
		else $error("count without rising edge");
endmodule

//--- rtl/tmcc_pkg.sv
// Purpose: constants shared by the timer module common core
// Assumes: 250 MHz system clock, byte-wide register port
// Notes: field positions follow the control byte layouts
package tmcc_pkg;
	localparam int CNT_W = 10;
	localparam int PRESC_W = 6;
	// clock select codes
	localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CKS_SYS = 3'h1;
	localparam logic [2:0] CKS_HS_DIV16 = 3'h2;
	localparam logic [2:0] CKS_HS_DIV64 = 3'h3;
	localparam logic [2:0] CKS_SUB_A = 3'h4;
	localparam logic [2:0] CKS_SUB_B = 3'h5;
	localparam logic [2:0] CKS_EXT_RISE = 3'h6;
	localparam logic [2:0] CKS_EXT_FALL = 3'h7;
	// register addresses on the byte port
	localparam logic [2:0] ADDR_CNT_LO = 3'h0;
	localparam logic [2:0] ADDR_CNT_HI = 3'h1;
	localparam logic [2:0] ADDR_CMPA_LO = 3'h2;
	localparam logic [2:0] ADDR_CMPA_HI = 3'h3;
	localparam logic [2:0] ADDR_CMPP_LO = 3'h4;
	localparam logic [2:0] ADDR_CMPP_HI = 3'h5;
	// reset values
	localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
	localparam logic [7:0] BUF_RST = 8'h00;
	// output action codes
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// capture edge select codes
	localparam logic [1:0] CAP_RISE = 2'h0;
	localparam logic [1:0] CAP_FALL = 2'h1;
	localparam logic [1:0] CAP_BOTH = 2'h2;
	// prescale tap masks
	localparam logic [PRESC_W-1:0] DIV4_MASK = 6'h03;
	localparam logic [PRESC_W-1:0] DIV16_MASK = 6'h0F;
	localparam logic [PRESC_W-1:0] DIV64_MASK = 6'h3F;
	typedef enum logic [1:0] {
		TMCC_MODE_CMP,
		TMCC_MODE_CAPTURE,
		TMCC_MODE_PWM,
		TMCC_MODE_SINGLE
	} tmcc_mode_t;
endpackage

//--- tb/testbench.sv
// Purpose: self-checking bench of the timer module common core
// Assumes: byte port strobes of one cycle, reads answered next cycle
// Notes: high-speed and sub ticks stay idle, system and pin clock paths only
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	import tmcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_n_i = 0, on = 0, pau = 0, act_init = 0, clr_a = 1, cfp = 0;
	logic [2:0] cks = CKS_SYS, addr = 3'h0;
	tmcc_mode_t mode = TMCC_MODE_CMP;
	logic [1:0] act = ACT_TOGGLE, cap_sel = CAP_RISE;
	logic wr = 0, rd = 0, start = 0, psel = 0, busy, ext_pin, cap_pin;
	logic [7:0] wdata = 8'h00, rdata;
	logic [3:0] npulse = 4'h0;
	logic irq_a, irq_p, cap_ev, outp, outn;
	int mismatches = 0, cmp_count = 0, cycles = 0, cap_cnt = 0;
	always #2 clk_i = ~clk_i;
	tmcc_pin_model tmcc_pin_model_i (.clk_i(clk_i), .start_i(start), .sel_i(psel), .n_i(npulse),
		.busy_o(busy), .ext_clk_o(ext_pin), .cap_o(cap_pin));
	tmcc_core tmcc_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .module_on_control_i(on),
		.counter_pause_control_i(pau), .counter_clock_select_i(cks), .mode_i(mode),
		.output_action_i(act), .output_initial_i(act_init), .clear_on_a_i(clr_a),
		.capture_edge_select_i(cap_sel), .capture_from_clock_pin_i(cfp), .high_speed_tick_i(1'b0),
		.sub_clock_tick_i(1'b0), .external_clock_pin_i(ext_pin), .capture_pin_i(cap_pin),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.irq_a_o(irq_a), .irq_p_o(irq_p), .capture_event_o(cap_ev), .timer_output_pin_o(outp),
		.timer_output_inverted_pin_o(outn));
	always @(negedge clk_i) if (cap_ev === 1'b1) cap_cnt++;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr = 1; addr = a; wdata = d;
		@(negedge clk_i);
		wr = 0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk_i);
		rd = 1; addr = a;
		@(negedge clk_i);
		rd = 0;
		d = rdata;
	endtask
	task automatic rd_pair(input logic [2:0] hi, output logic [9:0] v);
		logic [7:0] h, l;
		rd_reg(hi, h);
		rd_reg(hi - 3'h1, l);
		v = {h[1:0], l};
	endtask
	task automatic wait_irq(input bit p, output int n);
		n = 0;
		do begin @(negedge clk_i); n++; end while (((p ? irq_p : irq_a) !== 1'b1) && n < 300);
	endtask
	task automatic pulses(input bit s, input logic [3:0] n);
		@(negedge clk_i);
		psel = s; npulse = n; start = 1;
		@(negedge clk_i);
		start = 0;
		while (busy === 1'b1) @(negedge clk_i);
		repeat (6) @(negedge clk_i);
	endtask
	task automatic t_reset();
		logic [9:0] v;
		`CHK({irq_a, irq_p, outp, outn}, 4'h1) // inverse at reset
		rd_pair(ADDR_CNT_HI, v);
		`CHK(v, CNT_RST)
	endtask
	task automatic t_bytes();
		logic [9:0] v;
		logic [7:0] b;
		wr_reg(ADDR_CMPA_LO, 8'h34);
		rd_reg(ADDR_CMPA_LO, b);
		`CHK(b, 8'h34) // buffer returned
		rd_pair(ADDR_CMPA_HI, v);
		`CHK(v, 10'h000) // active low untouched
		wr_reg(ADDR_CMPA_LO, 8'h10);
		wr_reg(ADDR_CMPA_HI, 8'h00);
		wr_reg(ADDR_CMPA_LO, 8'h56);
		rd_pair(ADDR_CMPA_HI, v);
		`CHK(v, 10'h010) // snapshot on high read
	endtask
	task automatic t_match();
		int n;
		logic o1;
		on = 1;
		wait_irq(0, n);
		@(negedge clk_i) o1 = outp;
		wait_irq(0, n);
		`CHK(n, 16) // period of cmp plus one, less the cycle spent above
		@(negedge clk_i);
		`CHK(outp, ~o1) // toggle on match
		`CHK(outn, ~outp)
		wr_reg(ADDR_CMPP_LO, 8'h08);
		wr_reg(ADDR_CMPP_HI, 8'h00);
		clr_a = 0;
		wait_irq(1, n);
		wait_irq(1, n);
		`CHK(n, 9) // clear follows comparator P
	endtask
	task automatic t_hold();
		logic [9:0] v1, v2;
		pau = 1;
		rd_pair(ADDR_CNT_HI, v1);
		repeat (10) @(negedge clk_i);
		rd_pair(ADDR_CNT_HI, v2);
		`CHK(v2, v1) // pause holds
		pau = 0;
		on = 0;
		rd_pair(ADDR_CNT_HI, v1);
		repeat (10) @(negedge clk_i);
		rd_pair(ADDR_CNT_HI, v2);
		`CHK(v2, v1) // off freezes
	endtask
	task automatic t_ext(input logic [2:0] sel);
		logic [9:0] v;
		cks = sel; clr_a = 1;
		wr_reg(ADDR_CMPA_LO, 8'hFF);
		wr_reg(ADDR_CMPA_HI, 8'h03);
		on = 1;
		pulses(0, 4'h5);
		on = 0;
		rd_pair(ADDR_CNT_HI, v);
		`CHK(v, 10'h005) // one count per edge
	endtask
	task automatic t_cap(input logic [1:0] es, input int exp_n, input bit s);
		cap_sel = es;
		cfp = ~s;
		mode = TMCC_MODE_CAPTURE;
		cap_cnt = 0;
		pulses(s, 4'h2);
		`CHK(cap_cnt, exp_n) // one event per active edge
	endtask
	task automatic t_pwm();
		int n;
		on = 0; mode = TMCC_MODE_PWM; cks = CKS_SYS; clr_a = 0; act_init = 0;
		wr_reg(ADDR_CMPA_LO, 8'h03);
		wr_reg(ADDR_CMPA_HI, 8'h00);
		on = 1;
		wait_irq(1, n);
		`CHK(outp, 1'b1) // period match sets active level
		wait_irq(0, n);
		`CHK(n, 4) // duty from comparator A
		`CHK(outp, 1'b0) // duty match restores initial level
	endtask
	task automatic t_single();
		int n;
		on = 0; mode = TMCC_MODE_SINGLE; cks = CKS_SYS; clr_a = 1; act_init = 0;
		wr_reg(ADDR_CMPA_LO, 8'h40);
		wr_reg(ADDR_CMPA_HI, 8'h00);
		on = 1;
		@(negedge clk_i);
		@(negedge clk_i);
		`CHK(outp, 1'b0) // initial level loaded on switch-on
		pulses(0, 4'h1);
		`CHK(outp, 1'b1) // clock pin triggers pulse
		wait_irq(0, n);
		`CHK(outp, 1'b0) // pulse ends on comparator A
	endtask
	initial begin
		repeat (3) @(negedge clk_i);
		rst_n_i = 1;
		t_reset();
		t_bytes();
		t_match();
		t_hold();
		t_ext(CKS_EXT_RISE);
		t_ext(CKS_EXT_FALL);
		on = 1;
		t_cap(CAP_RISE, 2, 0);
		t_cap(CAP_RISE, 2, 1);
		t_cap(CAP_FALL, 2, 1);
		t_cap(CAP_BOTH, 4, 1);
		t_pwm();
		t_single();
		tally_and_finish();
	end
endmodule

//--- tb/tmcc_pin_model.sv
// Purpose: far-side pin driver for the timer core, clock pin and capture pin
// Assumes: pin functions already routed to the timer
// Notes: pins idle low and stand still outside a pulse train
module tmcc_pin_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic sel_i,
	input wire logic [3:0] n_i,
	output logic busy_o,
	output logic ext_clk_o,
	output logic cap_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int left;
	logic lvl;
	assign ext_clk_o = !sel_i & lvl;
	assign cap_o = sel_i & lvl;
	assign busy_o = (left != 0);
	initial begin
		left = 0;
		lvl = 1'b0;
	end
	// slow pulses so the two-stage synchroniser sees every level
	// rising edge: the bench changes start on the falling edge, so no race
	always @(posedge clk_i) begin
		if (start_i) begin
			left = 8 * n_i;
		end else if (left != 0) begin
			left = left - 1;
			lvl = (left % 8) >= 4;
		end
	end
endmodule
